// [design/pptg_pkg.sv]
// Constants, register map and field layout of the passive panel timing block.
// -----------------------------------------------------------------------------
// How it works
// - Horizontal total is (field+1) times eight.
// - Display width is (field+1) times eight pixels.
// - Passive display start is field plus 22.
// - Active-matrix display start is field plus five.
// - Line pulse starts at field plus one.
// - Line pulse lasts width field plus one.
// - Vertical total is field plus one lines.
// - Display height is field plus one lines.
// - Vertical display start is field, no offset.
// - Frame pulse lasts width field plus one lines.
// - Panel type 00b selects passive operation.
// - Frame polarity bit set means active high.
// - Line polarity bit set means active high.
// - Drive toggles per frame, or every n lines.
// - Drive changes well before line pulse rise.
// - First shift rise lands at display start.
// - Four-bit mode: upper nibble, period four.
// - Eight-bit mode: full byte, period eight.
// - Last shift fall comes half a period before display end.
// - Power save forces panel outputs low quickly.
// -----------------------------------------------------------------------------
package pptg_pkg;

  localparam int NREG = 10;
  localparam int REG_AW = 8;

  // Writable register offsets in the order of the register array, then the read-only ADR_STATUS.
  localparam logic [7:0] ADR_PANEL_TYPE = 8'h0c;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_HT = 8'h20;
  localparam logic [7:0] ADR_HDP = 8'h24;
  localparam logic [7:0] ADR_HORIZONTAL_DISPLAY_START = 8'h28;
  localparam logic [7:0] ADR_LINE = 8'h2c;
  localparam logic [7:0] ADR_VT = 8'h30;
  localparam logic [7:0] ADR_VDP = 8'h34;
  localparam logic [7:0] ADR_VERTICAL_DISPLAY_START = 8'h38;
  localparam logic [7:0] ADR_FRAME = 8'h3c;
  localparam logic [7:0] ADR_STATUS = 8'h40;

  localparam logic [7:0] REG_ADR [NREG] = '{ADR_PANEL_TYPE, ADR_CTRL, ADR_HT,
    ADR_HDP, ADR_HORIZONTAL_DISPLAY_START, ADR_LINE, ADR_VT, ADR_VDP, ADR_VERTICAL_DISPLAY_START, ADR_FRAME};
  localparam logic [31:0] REG_MASK [NREG] = '{32'h003f_0003, 32'h0000_0011,
    32'h0000_007f, 32'h0000_007f, 32'h0000_03ff, 32'h00ff_03ff, 32'h0000_03ff,
    32'h0000_03ff, 32'h0000_03ff, 32'h0087_0000};
  localparam logic [31:0] REG_RST [NREG] = '{32'h0000_0000, 32'h0000_0010,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  localparam int IDX_PANEL_TYPE = 0;
  localparam int IDX_CTRL = 1;
  localparam int IDX_HT = 2;
  localparam int IDX_HDP = 3;
  localparam int IDX_HORIZONTAL_DISPLAY_START = 4;
  localparam int IDX_LINE = 5;
  localparam int IDX_VT = 6;
  localparam int IDX_VDP = 7;
  localparam int IDX_VERTICAL_DISPLAY_START = 8;
  localparam int IDX_FRAME = 9;

  // Field positions.
  localparam int PTYPE_LSB = 0;
  localparam int MODRATE_LSB = 16;
  localparam int WIDTH8_BIT = 0;
  localparam int PSAVE_BIT = 4;
  localparam int POL_BIT = 23;
  localparam int LPW_LSB = 16;
  localparam int FPW_LSB = 16;
  localparam int STAT_VDISP_BIT = 16;
  localparam logic [1:0] PTYPE_STN = 2'h0;

  // Timing offsets in pixel clocks.
  localparam logic [11:0] HORIZONTAL_DISPLAY_START_STN_OFS = 12'h016;
  localparam logic [11:0] HORIZONTAL_DISPLAY_START_TFT_OFS = 12'h005;
  localparam int H_UNIT_SHIFT = 3;

endpackage

// [design/pptg_timing_gen.sv]
// Passive monochrome panel timing generator with a classic Wishbone slave.
`timescale 1ns/1ns
module pptg_timing_gen
  import pptg_pkg::*;
(
  input wire logic clk_i, // Pixel clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write enable.
  input wire logic [REG_AW-1:0] wb_adr_i, // Byte address.
  input wire logic [31:0] wb_dat_i, // Write data.
  input wire logic [3:0] wb_sel_i, // Byte lane selects.
  input wire logic [7:0] pixel_data_i, // Next panel data word.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Bus acknowledge.
  output logic frame_pulse_o, // Frame pulse.
  output logic line_pulse_o, // Line pulse.
  output logic shift_clock_o, // Shift clock.
  output logic alternating_drive_o, // Alternating drive.
  output logic panel_data_ready_o, // High while panel data is valid.
  output logic [7:0] panel_data_o, // Panel data lines.
  output logic pixel_take_o // Pulse: pixel_data_i was consumed.
);

  // ---------------------------------------------------------------------------
  // Register file and bus slave
  // ---------------------------------------------------------------------------
  logic [31:0] regs_q [NREG];
  logic [31:0] regs_d [NREG];
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [10:0] v_cnt_q;
  logic v_disp;

  always_comb
  begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    for (int i = 0; i < NREG; i++)
    begin
      regs_d[i] = regs_q[i];
      if (wb_adr_i == REG_ADR[i])
      begin
        rdat_d = regs_q[i] & REG_MASK[i];
        // The write lands at the edge where the master samples ack.
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q)
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
            begin
              regs_d[i][8*b +: 8] = wb_dat_i[8*b +: 8] & REG_MASK[i][8*b +: 8];
            end
          end
        end
      end
    end
    if (wb_adr_i == ADR_STATUS)
    begin
      rdat_d = {15'h0000, v_disp, 5'h00, v_cnt_q};
    end
    // Unmapped offsets are acknowledged and read as zero.
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs_q[i] <= REG_RST[i];
      end
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      regs_q <= regs_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------------------
  // Timing values derived from the fields
  // ---------------------------------------------------------------------------
  logic stn;
  logic wide;
  logic psave;
  logic [5:0] mod_rate;
  logic fp_pol;
  logic lp_pol;
  logic [11:0] ht;
  logic [11:0] horizontal_display_period;
  logic [11:0] horizontal_display_start;
  logic [11:0] line_pulse_start;
  logic [11:0] line_pulse_width;
  logic [10:0] vt;
  logic [10:0] vertical_display_period;
  logic [10:0] vertical_display_start;
  logic [10:0] frame_pulse_width;

  assign stn = regs_q[IDX_PANEL_TYPE][PTYPE_LSB +: 2] == PTYPE_STN;
  assign mod_rate = regs_q[IDX_PANEL_TYPE][MODRATE_LSB +: 6];
  assign wide = regs_q[IDX_CTRL][WIDTH8_BIT];
  assign psave = regs_q[IDX_CTRL][PSAVE_BIT];
  assign fp_pol = regs_q[IDX_FRAME][POL_BIT];
  assign lp_pol = regs_q[IDX_LINE][POL_BIT];
  assign ht = ({5'h00, regs_q[IDX_HT][6:0]} + 12'h001) << H_UNIT_SHIFT;
  assign horizontal_display_period = ({5'h00, regs_q[IDX_HDP][6:0]} + 12'h001) << H_UNIT_SHIFT;
  // A non-passive panel type only moves the display start here.
  assign horizontal_display_start = {2'h0, regs_q[IDX_HORIZONTAL_DISPLAY_START][9:0]} +
    (stn ? HORIZONTAL_DISPLAY_START_STN_OFS : HORIZONTAL_DISPLAY_START_TFT_OFS);
  assign line_pulse_start = {2'h0, regs_q[IDX_LINE][9:0]} + 12'h001;
  assign line_pulse_width = {5'h00, regs_q[IDX_LINE][LPW_LSB +: 7]} + 12'h001;
  assign vt = {1'b0, regs_q[IDX_VT][9:0]} + 11'h001;
  assign vertical_display_period = {1'b0, regs_q[IDX_VDP][9:0]} + 11'h001;
  assign vertical_display_start = {1'b0, regs_q[IDX_VERTICAL_DISPLAY_START][9:0]};
  assign frame_pulse_width = {8'h00, regs_q[IDX_FRAME][FPW_LSB +: 3]} + 11'h001;

  // ---------------------------------------------------------------------------
  // Line and frame counters
  // ---------------------------------------------------------------------------
  logic [11:0] h_cnt_q;
  logic [11:0] h_cnt_d;
  logic [10:0] v_cnt_d;
  logic line_end;
  logic frame_end;

  // Compares use >= so that shrinking a total mid-frame cannot strand a count.
  assign line_end = h_cnt_q >= ht - 12'h001;
  assign frame_end = v_cnt_q >= vt - 11'h001;

  always_comb
  begin
    h_cnt_d = line_end ? 12'h000 : h_cnt_q + 12'h001;
    v_cnt_d = v_cnt_q;
    if (line_end)
    begin
      v_cnt_d = frame_end ? 11'h000 : v_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      h_cnt_q <= 12'h000;
      v_cnt_q <= 11'h000;
    end
    else
    begin
      h_cnt_q <= h_cnt_d;
      v_cnt_q <= v_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Alternating drive
  // ---------------------------------------------------------------------------
  logic mod_q;
  logic mod_d;
  logic [5:0] mod_cnt_q;
  logic [5:0] mod_cnt_d;

  // The toggle happens at line start, so it leads the line pulse by at least
  // the line pulse start position.
  always_comb
  begin
    mod_d = mod_q;
    mod_cnt_d = mod_cnt_q;
    if (line_end)
    begin
      if (mod_rate == 6'h00)
      begin
        mod_cnt_d = 6'h00;
        if (frame_end)
        begin
          mod_d = !mod_q;
        end
      end
      else if (mod_cnt_q + 6'h01 >= mod_rate)
      begin
        mod_cnt_d = 6'h00;
        mod_d = !mod_q;
      end
      else
      begin
        mod_cnt_d = mod_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mod_q <= 1'b0;
      mod_cnt_q <= 6'h00;
    end
    else
    begin
      mod_q <= mod_d;
      mod_cnt_q <= mod_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Panel outputs
  // ---------------------------------------------------------------------------
  logic h_disp;
  logic lp_act;
  logic fp_act;
  logic [11:0] rel;
  logic shift_hi;
  logic load;
  logic fp_q;
  logic fp_d;
  logic lp_q;
  logic lp_d;
  logic sc_q;
  logic sc_d;
  logic md_q;
  logic md_d;
  logic rdy_q;
  logic rdy_d;
  logic [7:0] dat_q;
  logic [7:0] dat_d;
  logic take_q;
  logic take_d;

  assign h_disp = (h_cnt_q >= horizontal_display_start) && (h_cnt_q < horizontal_display_start + horizontal_display_period);
  assign v_disp = (v_cnt_q >= vertical_display_start) && (v_cnt_q < vertical_display_start + vertical_display_period);
  assign lp_act = (h_cnt_q >= line_pulse_start) && (h_cnt_q < line_pulse_start + line_pulse_width);
  assign fp_act = v_cnt_q < frame_pulse_width;
  assign rel = h_cnt_q - horizontal_display_start;
  // Shift is high in the first half of each period, so the first rise sits
  // at display start and the last fall half a period before its end.
  assign shift_hi = wide ? !rel[2] : !rel[1];
  assign load = wide ? (rel[2:0] == 3'h0) : (rel[1:0] == 2'h0);

  always_comb
  begin
    fp_d = 1'b0;
    lp_d = 1'b0;
    sc_d = 1'b0;
    md_d = 1'b0;
    rdy_d = 1'b0;
    dat_d = dat_q;
    take_d = 1'b0;
    if (psave)
    begin
      dat_d = 8'h00;
    end
    else
    begin
      fp_d = fp_pol ? fp_act : !fp_act;
      lp_d = lp_pol ? lp_act : !lp_act;
      md_d = mod_q;
      if (h_disp && v_disp)
      begin
        sc_d = shift_hi;
        rdy_d = 1'b1;
        if (load)
        begin
          take_d = 1'b1;
          dat_d = wide ? pixel_data_i : {pixel_data_i[3:0], 4'h0};
        end
      end
    end
  end

  // Power save clears every panel output at the next edge.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fp_q <= 1'b0;
      lp_q <= 1'b0;
      sc_q <= 1'b0;
      md_q <= 1'b0;
      rdy_q <= 1'b0;
      dat_q <= 8'h00;
      take_q <= 1'b0;
    end
    else
    begin
      fp_q <= fp_d;
      lp_q <= lp_d;
      sc_q <= sc_d;
      md_q <= md_d;
      rdy_q <= rdy_d;
      dat_q <= dat_d;
      take_q <= take_d;
    end
  end

  assign frame_pulse_o = fp_q;
  assign line_pulse_o = lp_q;
  assign shift_clock_o = sc_q;
  assign alternating_drive_o = md_q;
  assign panel_data_ready_o = rdy_q;
  assign panel_data_o = dat_q;
  assign pixel_take_o = take_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence narrow_period_s;
    shift_clock_o [*2] ##1 !shift_clock_o [*2];
  endsequence

  sequence wide_period_s;
    shift_clock_o [*4] ##1 !shift_clock_o [*4];
  endsequence

  sequence disp_start_s;
    !psave && v_disp && h_cnt_q == horizontal_display_start && $stable(regs_q[IDX_CTRL]);
  endsequence

  line_wrap_a: assert property (line_end |=> h_cnt_q == 12'h000)
    else $error("line counter did not wrap at horizontal total");

  frame_wrap_a: assert property (line_end && frame_end |=> v_cnt_q == 11'h000)
    else $error("line count did not wrap at vertical total");

  disp_ready_a: assert property (disp_start_s |=> panel_data_ready_o)
    else $error("data ready not raised at display start");

  disp_end_a: assert property (!psave && h_cnt_q == horizontal_display_start + horizontal_display_period |=>
    !panel_data_ready_o && !shift_clock_o)
    else $error("display period ran past its width");

  narrow_shift_a: assert property ((disp_start_s and !wide) |=>
    narrow_period_s)
    else $error("four-bit shift clock period wrong");

  wide_shift_a: assert property ((disp_start_s and wide) |=>
    wide_period_s)
    else $error("eight-bit shift clock period wrong");

  line_edge_a: assert property (!psave && h_cnt_q == line_pulse_start |=>
    line_pulse_o == lp_pol)
    else $error("line pulse did not start at its position");

  line_width_a: assert property (!psave && h_cnt_q == line_pulse_start + line_pulse_width &&
    !lp_act |=> line_pulse_o != lp_pol)
    else $error("line pulse width wrong");

  frame_width_a: assert property (!psave && v_cnt_q == frame_pulse_width |=>
    frame_pulse_o != fp_pol)
    else $error("frame pulse width wrong");

  shift_idle_a: assert property (!(h_disp && v_disp) |=> !shift_clock_o)
    else $error("shift clock toggled outside display");

  drive_frame_a: assert property (!psave && mod_rate == 6'h00 && line_end &&
    frame_end |=> ##1 alternating_drive_o != $past(alternating_drive_o))
    else $error("alternating drive missed frame toggle");

  power_save_a: assert property (psave |=> !frame_pulse_o && !line_pulse_o &&
    !shift_clock_o && !panel_data_ready_o && panel_data_o == 8'h00)
    else $error("outputs not low in power save");

  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

// [verif/pptg_panel_model.sv]
// Passive monochrome panel model that measures the timing it receives.
`timescale 1ns/1ns
module pptg_panel_model
(
  input wire logic clk_i, // Pixel clock used to time edges.
  input wire logic frame_pulse_i, // Frame pulse.
  input wire logic line_pulse_i, // Line pulse.
  input wire logic shift_clock_i, // Shift clock.
  input wire logic alternating_drive_i, // Alternating drive.
  input wire logic [7:0] panel_data_i, // Panel data lines.
  input wire logic pol_i, // Active level of both pulses.
  output logic [31:0] m_o [13] // Measured gaps and counts.
);
  // ---------------------------------------------------------------
  // Edge timing
  // ---------------------------------------------------------------
  // The panel only sees edges, so every timing figure is a gap between two; the rest are counts and data.
  logic [31:0] t, tl, tf, tr, th, ts, td, ln, sh, dl, fl;
  logic lq, fq, sq, dq, arm, got;
  logic lp, fp;
  assign lp = line_pulse_i ~^ pol_i;
  assign fp = frame_pulse_i ~^ pol_i;
  initial
  begin
    {t, tl, tf, tr, th, ts, td, ln, sh, dl, fl} = '0;
    {lq, fq, sq, dq, arm, got} = '0;
  end
  always @(posedge clk_i)
  begin
    t = t + 32'h1;
    if (lp && !lq)
    begin
      m_o[0] = t - tl;
      if (td > tl)
        m_o[6] = t - td;
      if (sh != 32'h0)
      begin
        m_o[2] = sh;
        m_o[5] = t - ts;
        if (!got)
          m_o[10] = ln;
        got = 1'b1;
        dl = dl + 32'h1;
      end
      tl = t;
      ln = ln + 32'h1;
      sh = '0;
      arm = 1'b0;
    end
    if (!lp && lq)
    begin
      m_o[1] = t - tl;
      tf = t;
      arm = 1'b1;
    end
    if (shift_clock_i && !sq)
    begin
      if (arm)
        m_o[3] = t - tf;
      arm = 1'b0;
      sh = sh + 32'h1;
      th = t;
    end
    // Data is taken on the falling shift edge, as a real panel does.
    if (!shift_clock_i && sq)
    begin
      m_o[4] = t - th;
      ts = t;
      m_o[12] = {24'h0, panel_data_i};
    end
    if (alternating_drive_i != dq)
    begin
      td = t;
      fl = fl + 32'h1;
    end
    if (fp && !fq)
    begin
      m_o[7] = ln;
      m_o[9] = dl;
      m_o[11] = fl;
      {ln, dl, fl, got} = '0;
      tr = t;
    end
    if (!fp && fq)
      m_o[8] = t - tr;
    lq = lp;
    fq = fp;
    sq = shift_clock_i;
    dq = alternating_drive_i;
  end
endmodule

// [verif/pptg_timing_gen_bench.sv]
// Self-checking bench for the passive panel timing generator.
`timescale 1ns/1ns
module pptg_timing_gen_bench
  import pptg_pkg::*;
;
  logic clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, pol;
  logic [7:0] wb_adr_i, pixel_data_i, panel_data_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic wb_ack_o, frame_pulse_o, line_pulse_o, shift_clock_o;
  logic alternating_drive_o, panel_data_ready_o, pixel_take_o;
  logic [31:0] m [13];
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  pptg_timing_gen dut (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .pixel_data_i(pixel_data_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .frame_pulse_o(frame_pulse_o),
    .line_pulse_o(line_pulse_o),
    .shift_clock_o(shift_clock_o),
    .alternating_drive_o(alternating_drive_o),
    .panel_data_ready_o(panel_data_ready_o),
    .panel_data_o(panel_data_o),
    .pixel_take_o(pixel_take_o)
  );

  pptg_panel_model panel (
    .clk_i(clk_i),
    .frame_pulse_i(frame_pulse_o),
    .line_pulse_i(line_pulse_o),
    .shift_clock_i(shift_clock_o),
    .alternating_drive_i(alternating_drive_o),
    .panel_data_i(panel_data_o),
    .pol_i(pol),
    .m_o(m)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // About 4400 cycles are needed; the ceiling leaves ample margin.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus and panel helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 4'hf, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, 4'hf, q);
    check(q, e);
  endtask

  // Frame, line, shift, ready and data outputs must sit low while power save holds the panel off.
  task automatic quiet(input int n);
    logic [11:0] acc;
    acc = '0;
    repeat (n)
    begin
      @(posedge clk_i);
      acc |= {frame_pulse_o, line_pulse_o, shift_clock_o,
        panel_data_ready_o, panel_data_o};
    end
    check({20'h0, acc}, 32'h0);
  endtask

  // Any steady frame holds whole display lines, so one frame of counts is
  // fixed by the timing fields alone.
  task automatic frame_count(input logic [31:0] rdy_exp,
    input logic [31:0] take_exp);
    logic [31:0] r;
    logic [31:0] k;
    r = '0;
    k = '0;
    repeat (384)
    begin
      @(posedge clk_i);
      r += {31'h0, panel_data_ready_o};
      k += {31'h0, pixel_take_o};
    end
    check(r, rdy_exp);
    check(k, take_exp);
  endtask

  // Line pulse at 56 for 4, display 32 wide, 6 lines with 3 shown.
  task automatic setup(input logic [31:0] pt, input logic [31:0] ctl,
    input logic p);
    pol <= p;
    wr(ADR_PANEL_TYPE, pt);
    wr(ADR_HT, 32'h7);
    wr(ADR_HDP, 32'h3);
    wr(ADR_HORIZONTAL_DISPLAY_START, 32'h0);
    wr(ADR_LINE, {8'h0, p, 7'h3, 6'h0, 10'h037});
    wr(ADR_VT, 32'h5);
    wr(ADR_VDP, 32'h2);
    wr(ADR_VERTICAL_DISPLAY_START, 32'h1);
    wr(ADR_FRAME, {8'h0, p, 4'h0, 3'h1, 16'h0});
    wr(ADR_CTRL, ctl);
    repeat (900) @(posedge clk_i);
    check({31'h0, m[6] >= 32'h37}, 32'h1);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    rst_b_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    pixel_data_i = 8'ha5;
    pol = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    quiet(100);
    for (int i = 0; i < NREG; i++)
      rd_chk(REG_ADR[i], REG_RST[i]);
    for (int i = 0; i < NREG; i++)
      wr(REG_ADR[i], 32'hffff_ffff);
    for (int i = 0; i < NREG; i++)
      rd_chk(REG_ADR[i], REG_MASK[i]);
    bus(ADR_LINE, 1'b1, 32'h0, 4'h1, q);
    rd_chk(ADR_LINE, 32'h00ff_0300);
    wr(8'h80, 32'hffff_ffff);
    rd_chk(8'h80, 32'h0);
    $display("Register test done");
    setup(32'h0, 32'h0, 1'b1);
    check(m[0], 32'h40);
    check(m[1], 32'h4);
    check(m[2], 32'h8);
    check(m[3], 32'h1a);
    check(m[4], 32'h2);
    check(m[5], 32'h4);
    check(m[7], 32'h6);
    check(m[8], 32'h80);
    check(m[9], 32'h3);
    check(m[10], 32'h1);
    check(m[11], 32'h1);
    check(m[12], 32'h50);
    frame_count(32'h60, 32'h18);
    $display("Four-bit test done");
    setup(32'h0002_0000, 32'h1, 1'b1);
    check(m[2], 32'h4);
    check(m[3], 32'h1a);
    check(m[4], 32'h4);
    check(m[5], 32'h6);
    check(m[11], 32'h3);
    check(m[12], 32'ha5);
    frame_count(32'h60, 32'h0c);
    $display("Eight-bit test done");
    setup(32'h1, 32'h1, 1'b0);
    check(m[0], 32'h40);
    check(m[1], 32'h4);
    check(m[3], 32'h9);
    check(m[5], 32'h17);
    check(m[8], 32'h80);
    frame_count(32'h60, 32'h0c);
    $display("Other type test done");
    wr(ADR_CTRL, 32'h11);
    quiet(200);
    $display("Power save test done");
    complete_run();
  end
endmodule
